// file: rtl/iox_regs.svh
`ifndef IOX_REGS_SVH
`define IOX_REGS_SVH
// fixed upper address nibble
`define IOX_ADDR_HI 4'h3
// command byte register selects
`define IOX_SEL_INPUT 2'h0
`define IOX_SEL_OUTPUT 2'h1
`define IOX_SEL_POLARITY 2'h2
`define IOX_SEL_CONFIG 2'h3
// reset values
`define IOX_RST_OUTPUT 8'h00
`define IOX_RST_POLARITY 8'hF0
`define IOX_RST_CONFIG 8'hFF
// glitch filter: least width in ns, cycles at 5 ns rounded up
`define IOX_FILT_NS 50
`define IOX_CLK_NS 5
`define IOX_FILT_CYC ((`IOX_FILT_NS + `IOX_CLK_NS - 1) / `IOX_CLK_NS)
`endif

// file: rtl/iox_pkg.sv
package iox_pkg;
  typedef enum logic [4:0] {
    IOX_IDLE = 5'h01,
    IOX_RXB = 5'h02,
    IOX_ACK = 5'h04,
    IOX_TXB = 5'h08,
    IOX_RACK = 5'h10
  } iox_state_t;
  // one port direction of pins: drive value and enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } iox_pins_t;
endpackage

// file: rtl/iox_expander.sv
// Functional notes
// (RULE1) controller starts transfers only while bus idle
// (RULE2) sda falling while scl high is start; begin address reception
// (RULE3) address byte arrives msb first, direction bit last
// (RULE4) matching address acknowledged low through ninth clock high phase
// (RULE5) straps held start to stop; sampled once per transfer
// (RULE6) one bit per clock pulse; sda stable while scl high
// (RULE7) sda rising while scl high is stop; return to idle
// (RULE8) each byte eight bits plus one acknowledge; any byte count
// (RULE9) sender releases sda after eighth bit for acknowledge
// (RULE10) acknowledger holds sda low over acknowledge high phase
// (RULE11) every byte received from controller acknowledged
// (RULE12) controller acknowledges every read byte except last
// (RULE13) on read nack device releases sda for stop
// (RULE14) address bits three to one compared with straps
// (RULE15) upper address bits fixed 0011; base address 0x18
// (RULE16) four 8-bit registers: config, input, output, polarity
// (RULE17) after power-on all pins inputs, drivers off
// (RULE18) input register holds pin values, output register drive values
// (RULE19) input read inverted where polarity bit set
// (RULE20) all four registers readable
// (RULE21) power-on reset loads defaults and idles bus machine
// (RULE22) reset pin low does the same initialisation
// (RULE23) pin zero only pulls low or floats; others push-pull
// (RULE24) direction bit one reads, zero writes
// (RULE25) first write byte is command; low two bits select register
// (RULE26) selected register persists until new command
// (RULE27) config one means input, zero means output
// (RULE28) scl and sda synchronised and glitch-filtered before use
// (RULE29) non-matching address not acknowledged; bus ignored till start
// (RULE30) repeated start restarts address, selection kept
`include "iox_regs.svh"
module iox_expander
  import iox_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // two-wire bus, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // address straps
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  // port pins
  input wire logic [7:0] port_in,
  output logic [7:0] port_out,
  output logic [7:0] port_oe
);
  // two-flop synchronisers for every pin input
  logic [12:0] meta_ff, sync_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 13'h1FFF;
      sync_ff <= 13'h1FFF;
    end else begin
      meta_ff <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, port_in, scl_in, sda_in};
      sync_ff <= meta_ff;
    end
  end
  wire logic scl_s = sync_ff[1];
  wire logic sda_s = sync_ff[0];
  wire logic [7:0] pin_s = sync_ff[9:2];
  wire logic [2:0] strap_s = sync_ff[12:10];

  // glitch filter: a level must hold IOX_FILT_CYC cycles to be accepted
  localparam int FW = 4;
  logic [1:0] filt_ff, nxt_filt;
  logic [FW-1:0] fcnt_ff [2];
  logic [FW-1:0] nxt_fcnt [2];
  logic [1:0] filt_d_ff;
  wire logic [1:0] raw_s = {scl_s, sda_s};
  // (RULE28) filter both lines
  generate
    for (genvar g = 0; g < 2; g++) begin : g_filt
      always_comb begin
        nxt_filt[g] = filt_ff[g];
        nxt_fcnt[g] = '0;
        if (raw_s[g] != filt_ff[g]) begin
          nxt_fcnt[g] = fcnt_ff[g] + 4'h1;
          if (fcnt_ff[g] == FW'(`IOX_FILT_CYC - 1)) begin
            nxt_filt[g] = raw_s[g];
            nxt_fcnt[g] = '0;
          end
        end
      end
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          fcnt_ff[g] <= '0;
        end else begin
          fcnt_ff[g] <= nxt_fcnt[g];
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      filt_ff <= 2'h3;
      filt_d_ff <= 2'h3;
    end else begin
      filt_ff <= nxt_filt;
      filt_d_ff <= filt_ff;
    end
  end
  wire logic scl_f = filt_ff[1];
  wire logic sda_f = filt_ff[0];
  wire logic scl_rise = scl_f && !filt_d_ff[1];
  wire logic scl_fall = !scl_f && filt_d_ff[1];
  // (RULE2) start detect
  wire logic start_det = scl_f && filt_d_ff[1] && !sda_f && filt_d_ff[0];
  // (RULE7) stop detect
  wire logic stop_det = scl_f && filt_d_ff[1] && sda_f && !filt_d_ff[0];

  // (RULE16) bus engine and four registers
  iox_state_t st_ff, nxt_st;
  logic [7:0] sh_ff, nxt_sh;
  // counts to eight so the bit after a start is not mistaken for a full byte
  logic [3:0] bit_ff, nxt_bit;
  logic is_addr_ff, nxt_is_addr;
  logic is_cmd_ff, nxt_is_cmd;
  logic rd_ff, nxt_rd;
  logic nak_ff, nxt_nak;
  logic sda_oe_ff, nxt_sda_oe;
  logic [1:0] sel_ff, nxt_sel;
  logic [7:0] outr_ff, nxt_outr, pol_ff, nxt_pol, cfg_ff, nxt_cfg;
  logic [7:0] inr_ff;
  logic [2:0] strap_ff, nxt_strap;
  logic [7:0] rdata;

  // (RULE19) input readback inverted by polarity; (RULE20) all readable
  always_comb begin
    case (sel_ff)
      `IOX_SEL_INPUT: rdata = inr_ff ^ pol_ff;
      `IOX_SEL_OUTPUT: rdata = outr_ff;
      `IOX_SEL_POLARITY: rdata = pol_ff;
      default: rdata = cfg_ff;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_bit = bit_ff;
    nxt_is_addr = is_addr_ff;
    nxt_is_cmd = is_cmd_ff;
    nxt_rd = rd_ff;
    nxt_nak = nak_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_sel = sel_ff;
    nxt_outr = outr_ff;
    nxt_pol = pol_ff;
    nxt_cfg = cfg_ff;
    nxt_strap = strap_ff;
    if (stop_det) begin
      // (RULE7) back to idle, release line
      nxt_st = IOX_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (start_det) begin
      // (RULE30) restart keeps sel; (RULE5) straps sampled once here
      nxt_st = IOX_RXB;
      nxt_bit = 4'h0;
      nxt_is_addr = 1'b1;
      nxt_sda_oe = 1'b0;
      nxt_strap = strap_s;
    end else begin
      case (st_ff)
        IOX_RXB: begin
          // (RULE3) (RULE6) one bit per scl rise, msb first
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_f};
            nxt_bit = bit_ff + 4'h1;
          end
          // (RULE8) eighth bit done once scl falls after bit 7
          if (scl_fall && bit_ff == 4'h8) begin
            nxt_st = IOX_ACK;
            if (is_addr_ff) begin
              // (RULE14) (RULE15) address match
              if (sh_ff[7:1] == {`IOX_ADDR_HI, strap_ff}) begin
                nxt_sda_oe = 1'b1;
                // (RULE24) direction bit
                nxt_rd = sh_ff[0];
                nxt_is_cmd = !sh_ff[0];
              end else begin
                // (RULE29) no ack, ignore until next start
                nxt_st = IOX_IDLE;
              end
            end else begin
              // (RULE11) acknowledge every written byte
              nxt_sda_oe = 1'b1;
              if (is_cmd_ff) begin
                // (RULE25) (RULE26) command selects register
                nxt_sel = sh_ff[1:0];
                nxt_is_cmd = 1'b0;
              end else begin
                case (sel_ff)
                  `IOX_SEL_OUTPUT: nxt_outr = sh_ff;
                  `IOX_SEL_POLARITY: nxt_pol = sh_ff;
                  `IOX_SEL_CONFIG: nxt_cfg = sh_ff;
                  default: nxt_outr = outr_ff;
                endcase
              end
            end
            nxt_is_addr = 1'b0;
          end
        end
        IOX_ACK: begin
          // (RULE4) (RULE10) hold low through ack high phase, drop at fall
          if (scl_fall) begin
            nxt_bit = 4'h0;
            if (rd_ff) begin
              nxt_st = IOX_TXB;
              nxt_sh = rdata;
              nxt_sda_oe = !rdata[7];
            end else begin
              nxt_st = IOX_RXB;
              nxt_sda_oe = 1'b0;
            end
          end
        end
        IOX_TXB: begin
          if (scl_fall) begin
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h7) begin
              // (RULE9) release for controller ack
              nxt_st = IOX_RACK;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_sda_oe = !sh_ff[6];
            end
          end
        end
        IOX_RACK: begin
          if (scl_rise) begin
            nxt_nak = sda_f;
          end
          if (scl_fall) begin
            if (nak_ff) begin
              // (RULE13) nack: release and wait for stop
              nxt_st = IOX_IDLE;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_st = IOX_TXB;
              nxt_bit = 4'h0;
              nxt_sh = rdata;
              nxt_sda_oe = !rdata[7];
            end
          end
        end
        default: begin // idle and stray codes keep the line released
          nxt_st = IOX_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // (RULE21) (RULE22) async reset loads defaults and idles
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= IOX_IDLE;
      sh_ff <= 8'h00;
      bit_ff <= 4'h0;
      is_addr_ff <= 1'b0;
      is_cmd_ff <= 1'b0;
      rd_ff <= 1'b0;
      nak_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      sel_ff <= `IOX_SEL_INPUT;
      outr_ff <= `IOX_RST_OUTPUT;
      pol_ff <= `IOX_RST_POLARITY;
      cfg_ff <= `IOX_RST_CONFIG;
      strap_ff <= 3'h0;
      inr_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      bit_ff <= nxt_bit;
      is_addr_ff <= nxt_is_addr;
      is_cmd_ff <= nxt_is_cmd;
      rd_ff <= nxt_rd;
      nak_ff <= nxt_nak;
      sda_oe_ff <= nxt_sda_oe;
      sel_ff <= nxt_sel;
      outr_ff <= nxt_outr;
      pol_ff <= nxt_pol;
      cfg_ff <= nxt_cfg;
      strap_ff <= nxt_strap;
      // (RULE18) input register tracks pins
      inr_ff <= pin_s;
    end
  end

  // pin drivers registered; (RULE17) (RULE27) (RULE23)
  iox_pins_t pins_ff, nxt_pins;
  always_comb begin
    nxt_pins.out = outr_ff & 8'hFE;
    nxt_pins.oe = ~cfg_ff;
    // pin zero open drain: enable only when driving low
    nxt_pins.oe[0] = !cfg_ff[0] && !outr_ff[0];
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_ff <= '0;
    end else begin
      pins_ff <= nxt_pins;
    end
  end
  assign port_out = {pins_ff.out[7:1], 1'b0};
  assign port_oe = pins_ff.oe;
  assign sda_oe = sda_oe_ff;

  // (RULE17) idle reset state
  a_pins_reset: assert property (@(posedge clk_sys) $rose(rst_n) |-> port_oe == 8'h00) // (RULE17)
    else $error("pins driven after reset");
  // (RULE23) pin zero enabled only for a low output
  a_pin0_od: assert property (@(posedge clk_sys) disable iff (!rst_n) // (RULE23)
    port_oe[0] |-> !$past(outr_ff[0]) && !$past(cfg_ff[0])) else $error("pin zero driven high");
  // (RULE7) stop to idle
  a_stop_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // (RULE7)
    stop_det |=> st_ff == IOX_IDLE && !sda_oe) else $error("stop not honoured");
  // (RULE2) start to address
  a_start_rx: assert property (@(posedge clk_sys) disable iff (!rst_n) // (RULE2)
    start_det && !stop_det |=> st_ff == IOX_RXB) else $error("start not honoured");
  // (RULE29) foreign address ignored
  a_no_ack_mismatch: assert property (@(posedge clk_sys) disable iff (!rst_n) // (RULE29)
    st_ff == IOX_RXB && is_addr_ff && scl_fall && bit_ff == 4'h8 && !start_det && !stop_det
    && sh_ff[7:1] != {`IOX_ADDR_HI, strap_ff} |=> !sda_oe) else $error("acked foreign addr");
  // (RULE4) ack held high phase
  a_ack_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // (RULE4)
    st_ff == IOX_ACK && scl_f |-> sda_oe) else $error("ack released early");
  // (RULE9) released for controller ack
  a_rack_rel: assert property (@(posedge clk_sys) disable iff (!rst_n) // (RULE9)
    st_ff == IOX_RACK |-> !sda_oe) else $error("line held in ack slot");
  // (RULE27) direction follows config
  a_cfg_dir: assert property (@(posedge clk_sys) disable iff (!rst_n) // (RULE27)
    ##1 port_oe[7:1] == ~$past(cfg_ff[7:1])) else $error("direction mismatch");
endmodule // iox_expander

// file: sim/iox_i2c_ctl.sv
module iox_i2c_ctl #(
  parameter int QTR = 20
) (
  // system
  input wire logic clk_sys,
  // bus lines, resolved sda and controller drive (1 = released)
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 100ps;
  // bus idles released, pull-ups hold both lines high
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic start();
    tick(1);
    sda_drv <= 1'b1;
    tick(QTR);
    scl_drv <= 1'b1;
    tick(QTR);
    sda_drv <= 1'b0;
    tick(QTR);
    scl_drv <= 1'b0;
    tick(QTR);
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    tick(QTR);
    scl_drv <= 1'b1;
    tick(QTR);
    sda_drv <= 1'b1;
    tick(QTR);
  endtask
  // data moves only while scl low
  task automatic bit_xfer(input logic b, output logic r);
    sda_drv <= b;
    tick(QTR);
    scl_drv <= 1'b1;
    tick(QTR);
    @(negedge clk_sys);
    r = sda_line;
    tick(QTR);
    @(negedge clk_sys);
    r = r | sda_line; // low only if low at both samples taken in the high phase
    @(posedge clk_sys);
    scl_drv <= 1'b0;
    tick(QTR);
  endtask
  task automatic tx_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask
  // ack all read bytes but the last
  task automatic rx_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(last, r);
  endtask
endmodule // iox_i2c_ctl

// file: sim/iox_expander_tb_top.sv
module iox_expander_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic scl, sda_drv, sda_oe, sda;
  logic [2:0] strap = 3'h0;
  logic [7:0] ext = 8'h3C;
  logic [7:0] port_in, port_out, port_oe;
  int error_cnt = 0;
  int samples_checked = 0;
  always #2.5 clk_sys = ~clk_sys;
  // open-drain bus wire and pins: a driven pin shows its drive value
  assign sda = sda_drv & ~sda_oe;
  assign port_in = (port_oe & port_out) | (~port_oe & ext);
  iox_expander u_iox_expander (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_oe(sda_oe), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
    .addr_strap_bit2(strap[2]), .port_in(port_in), .port_out(port_out), .port_oe(port_oe));
  iox_i2c_ctl u_iox_i2c_ctl (.clk_sys(clk_sys), .sda_line(sda), .scl_drv(scl), .sda_drv(sda_drv));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [7:0] dev_addr(input logic rw);
    return {4'h3, strap, rw};
  endfunction
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    logic a;
    u_iox_i2c_ctl.start();
    u_iox_i2c_ctl.tx_byte(dev_addr(1'b0), a);
    check({7'h00, a}, 8'h01);
    u_iox_i2c_ctl.tx_byte(cmd, a);
    check({7'h00, a}, 8'h01);
    u_iox_i2c_ctl.tx_byte(data, a);
    check({7'h00, a}, 8'h01);
    u_iox_i2c_ctl.stop();
  endtask
  // two-byte read; without a command the last selection is read
  task automatic rd(input logic with_cmd, input logic [7:0] cmd, input logic [7:0] exp);
    logic a;
    logic [7:0] d;
    u_iox_i2c_ctl.start();
    if (with_cmd) begin
      u_iox_i2c_ctl.tx_byte(dev_addr(1'b0), a);
      u_iox_i2c_ctl.tx_byte(cmd, a);
      u_iox_i2c_ctl.start();
    end
    u_iox_i2c_ctl.tx_byte(dev_addr(1'b1), a);
    check({7'h00, a}, 8'h01);
    u_iox_i2c_ctl.rx_byte(1'b0, d);
    check(d, exp);
    u_iox_i2c_ctl.rx_byte(1'b1, d);
    check(d, exp);
    check({7'h00, sda_oe}, 8'h00);
    u_iox_i2c_ctl.stop();
  endtask
  initial begin
    logic a;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    u_iox_i2c_ctl.tick(5);
    check(port_oe, 8'h00);
    rd(1'b1, 8'h01, 8'h00);
    rd(1'b1, 8'h02, 8'hF0);
    rd(1'b1, 8'h03, 8'hFF);
    rd(1'b1, 8'h00, 8'hCC);
    $display("test defaults done");
    wr(8'h01, 8'hA5);
    wr(8'h03, 8'h00);
    check(port_out, 8'hA4);
    check(port_oe, 8'hFE);
    wr(8'h01, 8'hA4);
    check(port_oe, 8'hFF);
    rd(1'b1, 8'h00, 8'h54);
    wr(8'h02, 8'h0F);
    rd(1'b1, 8'h00, 8'hAB);
    wr(8'h03, 8'hFF);
    check(port_oe, 8'h00);
    // writes to the input register must not stick
    wr(8'h00, 8'h55);
    rd(1'b0, 8'h00, 8'h33);
    $display("test port control done");
    // straps change only while the bus is idle
    strap <= 3'h5;
    u_iox_i2c_ctl.start();
    u_iox_i2c_ctl.tx_byte(8'h30, a);
    check({7'h00, a}, 8'h00);
    u_iox_i2c_ctl.tx_byte(8'h01, a);
    check({7'h00, a}, 8'h00);
    u_iox_i2c_ctl.stop();
    rd(1'b1, 8'h02, 8'h0F);
    $display("test address done");
    wr(8'h01, 8'h5A);
    wr(8'h03, 8'h00);
    rst_n <= 1'b0;
    u_iox_i2c_ctl.tick(10);
    check(port_oe, 8'h00);
    rst_n <= 1'b1;
    u_iox_i2c_ctl.tick(5);
    rd(1'b1, 8'h01, 8'h00);
    rd(1'b1, 8'h03, 8'hFF);
    $display("test reset done");
    conclude();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end
endmodule // iox_expander_tb_top
